// file: tpwm_timer.sv
// One-pulse and PWM modes of a 16-bit free-running timer.
// Assumes synchronous pins, a CPU-side access strobe group and an
// external core mask; halt and wait come from the power controller.
`timescale 1ns/1ps

module tpwm_timer (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 clk_en_i,
  input  wire tpwm_pkg::tpwm_ctrl_t ctrl_i,
  input  wire tpwm_pkg::tpwm_acc_t  acc_i,
  input  wire logic                 core_mask_i,
  input  wire logic                 halt_i,
  input  wire logic                 halt_wake_i,
  input  wire logic                 trig_in1_i,
  input  wire logic                 cap_in2_i,
  input  wire logic                 ext_clk_i,
  input  wire logic                 gpio_out_i,
  output logic                      wave_out1_o,
  output logic [15:0]               counter_o,
  output logic [15:0]               capture1_value_o,
  output logic [15:0]               capture2_value_o,
  output logic [15:0]               compare1_value_o,
  output logic [15:0]               compare2_value_o,
  output logic [7:0]                flag_reg_o,
  output logic                      timer_irq_o,
  output logic                      wait_wake_o
);
  import tpwm_pkg::*;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  tpwm_mode_t mode;
  wire        pwm_on   = ctrl_i.pwm_sel;
  // Select bit gates pulse; PWM wins
  wire        pulse_on = ctrl_i.single_pulse_sel & ~ctrl_i.pwm_sel;
  assign mode = pwm_on ? TPWM_MODE_PWM : (pulse_on ? TPWM_MODE_PULSE : TPWM_MODE_NORMAL);

  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (~prev & cur) : (prev & ~cur);
  endfunction

  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cmp1_q, cmp2_q, cap1_q, cap2_q;
  logic [2:0]  pre_q;
  logic        trig_prev_q, cap2_prev_q, ext_prev_q;
  logic        cap1_f_q, cap2_f_q, cmp1_f_q, cmp2_f_q, ovf_f_q;
  logic [4:0]  armed_q;
  logic [1:0]  cmp_hold_q;
  logic        cap1_inh_q, cap2_inh_q;
  logic        wave_q;
  logic        arm1_q, arm2_q;
  logic        primed_q;

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  // Divider select decode
  wire [2:0] pre_mask = (ctrl_i.tick_div_sel == TPWM_DIV2_SEL) ? TPWM_DIV2_MASK :
                        (ctrl_i.tick_div_sel == TPWM_DIV8_SEL) ? TPWM_DIV8_MASK :
                        TPWM_DIV4_MASK;
  // No edges until the previous-sample flops hold a real pin value
  wire ext_tick = primed_q & edge_hit(ext_prev_q, ext_clk_i, ctrl_i.ext_edge_sel);
  wire run  = clk_en_i & ~halt_i;
  wire tick = run & ((ctrl_i.tick_div_sel == TPWM_EXT_SEL) ? ext_tick
                                                           : ((pre_q & pre_mask) == pre_mask));

  // ----------------------------------------
  // Compare and capture events
  // ----------------------------------------
  // Compare suspended between high and low byte writes
  wire match1 = tick & ~cmp_hold_q[0] & (cnt_q == cmp1_q);
  wire match2 = tick & ~cmp_hold_q[1] & (cnt_q == cmp2_q);
  wire trig_hit  = primed_q & edge_hit(trig_prev_q, trig_in1_i, ctrl_i.edge1_sel);
  wire cap2_hit  = primed_q & edge_hit(cap2_prev_q, cap_in2_i, ctrl_i.edge2_sel);
  wire trig_edge = run & trig_hit;
  wire cap2_edge = run & cap2_hit;
  wire pulse_trig = pulse_on & trig_edge;
  wire norm_cap1  = (mode == TPWM_MODE_NORMAL) & trig_edge & ~cap1_inh_q;
  // Armed captures land on halt exit
  wire wake_cap1  = halt_wake_i & arm1_q & ~cap1_inh_q;
  wire wake_cap2  = halt_wake_i & arm2_q & ~cap2_inh_q;
  // PWM period end sets capture1 flag
  wire set_cap1 = norm_cap1 | pulse_trig | (pwm_on & match2) | wake_cap1;
  // Capture2 keeps working in every mode
  wire set_cap2 = (cap2_edge & ~cap2_inh_q) | wake_cap2;
  // No compare1 flag in pulse mode; none in PWM
  wire set_cmp1 = match1 & (mode == TPWM_MODE_NORMAL);
  wire set_cmp2 = match2 & ~pwm_on;
  wire reload   = pulse_trig | (pwm_on & match2);
  // Rollover flag; a reload on that tick is no rollover
  wire set_ovf  = tick & (cnt_q == 16'hFFFF) & ~reload;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Trigger reload; period reload; FFFC start adds four ticks
  always_comb begin
    cnt_d = cnt_q;
    if (reload) begin
      cnt_d = TPWM_RELOAD_VAL;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q       <= TPWM_CNT_RESET;
      pre_q       <= 3'h0;
      trig_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
      ext_prev_q  <= 1'b0;
      primed_q    <= 1'b0;
    end else if (clk_en_i) begin
      cnt_q       <= cnt_d;
      pre_q       <= halt_i ? pre_q : pre_q + 3'h1;
      trig_prev_q <= trig_in1_i;
      cap2_prev_q <= cap_in2_i;
      ext_prev_q  <= ext_clk_i;
      primed_q    <= 1'b1;
    end
  end

  // ----------------------------------------
  // Capture and compare registers
  // ----------------------------------------
  wire [7:0] wd = acc_i.wr_data;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cap1_q     <= 16'h0000;
      cap2_q     <= 16'h0000;
      cmp1_q     <= TPWM_CMP_RESET;
      cmp2_q     <= TPWM_CMP_RESET;
      cmp_hold_q <= 2'h0;
      cap1_inh_q <= 1'b0;
      cap2_inh_q <= 1'b0;
      arm1_q     <= 1'b0;
      arm2_q     <= 1'b0;
    end else if (clk_en_i) begin
      // Pulse trigger loads FFFD into capture1
      if (pulse_trig) begin
        cap1_q <= TPWM_CAP1_PULSE;
      end else if (norm_cap1 | wake_cap1) begin
        cap1_q <= cnt_q;
      end
      if (set_cap2) begin
        cap2_q <= cnt_q;
      end
      if (acc_i.cmp_hi_wr[0]) cmp1_q[15:8] <= wd;
      if (acc_i.cmp_lo_wr[0]) cmp1_q[7:0]  <= wd;
      if (acc_i.cmp_hi_wr[1]) cmp2_q[15:8] <= wd;
      if (acc_i.cmp_lo_wr[1]) cmp2_q[7:0]  <= wd;
      // Hold from high write to low write
      cmp_hold_q <= (cmp_hold_q | acc_i.cmp_hi_wr) & ~acc_i.cmp_lo_wr;
      cap1_inh_q <= (cap1_inh_q | acc_i.cap1_hi_rd) & ~acc_i.cap1_lo_acc;
      cap2_inh_q <= (cap2_inh_q | acc_i.cap2_hi_rd) & ~acc_i.cap2_lo_acc;
      // Arm on edges seen while halted
      arm1_q <= halt_wake_i ? 1'b0
              : (arm1_q | (halt_i & (mode == TPWM_MODE_NORMAL)
                           & trig_hit));
      arm2_q <= halt_wake_i ? 1'b0
              : (arm2_q | (halt_i & cap2_hit));
    end
  end

  // ----------------------------------------
  // Flags with two-step clear
  // ----------------------------------------
  // Flag read while set arms the clear; low byte access finishes it
  wire [4:0] flag_vec = {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q};
  wire [4:0] flag_set = {set_cap1, set_cmp1, set_ovf, set_cap2, set_cmp2};
  wire [4:0] flag_acc = {acc_i.cap1_lo_acc, acc_i.cmp1_lo_acc, acc_i.cnt_lo_acc,
                         acc_i.cap2_lo_acc, acc_i.cmp2_lo_acc};
  wire [4:0] flag_clr = flag_acc & armed_q;
  // Set wins over a clear in the same cycle
  wire [4:0] flag_nxt = flag_set | (flag_vec & ~flag_clr);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q} <= 5'h00;
      armed_q <= 5'h00;
    end else if (clk_en_i) begin
      {cap1_f_q, cmp1_f_q, ovf_f_q, cap2_f_q, cmp2_f_q} <= flag_nxt;
      armed_q <= acc_i.flag_reg_rd ? (flag_vec | armed_q) & ~flag_clr
                                   : armed_q & ~flag_clr;
    end
  end

  // ----------------------------------------
  // Waveform output
  // ----------------------------------------
  // Match1 ends pulse; match2 never drives a pin in pulse mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_q <= 1'b0;
    end else if (clk_en_i) begin
      if (pulse_trig) begin
        wave_q <= ctrl_i.cmp2_level;
      end else if (pwm_on & match2) begin
        wave_q <= ctrl_i.cmp2_level;
      end else if (match1) begin
        wave_q <= ctrl_i.cmp1_level;
      end
    end
  end

  // Pin falls back to the port latch when disabled
  assign wave_out1_o = ctrl_i.wave1_pin_en ? wave_q : gpio_out_i;

  // ----------------------------------------
  // Interrupt and wake
  // ----------------------------------------
  // Capture flags gated by capture enable
  wire irq_req = (ctrl_i.cap_irq_en & (cap1_f_q | cap2_f_q))
               | (ctrl_i.cmp_irq_en & (cmp1_f_q | cmp2_f_q))
               | (ctrl_i.ovf_irq_en & ovf_f_q);
  // One line gated by core mask; wait wake only
  assign timer_irq_o = irq_req & ~core_mask_i;
  // Wake from wait on any enabled, unmasked event
  assign wait_wake_o = timer_irq_o & ~halt_i;

  assign counter_o        = cnt_q;
  assign capture1_value_o = cap1_q;
  assign capture2_value_o = cap2_q;
  assign compare1_value_o = cmp1_q;
  assign compare2_value_o = cmp2_q;
  assign flag_reg_o       = {flag_vec, 3'h0};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_trig;
    clk_en_i && pulse_trig;
  endsequence

  a_pulse_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_trig |=> cnt_q == 16'hFFFC && cap1_q == 16'hFFFD && cap1_f_q)
    else $error("pulse trigger did not reload");
  a_pulse_end_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && pulse_on && match1 && !pulse_trig) |=> wave_q == $past(ctrl_i.cmp1_level))
    else $error("pulse end level wrong");
  a_no_cmp1_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && pulse_on && !cmp1_f_q) |=> !cmp1_f_q)
    else $error("compare1 flag set in pulse mode");
  a_pwm_period: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && pwm_on && match2) |=> cnt_q == 16'hFFFC && cap1_f_q)
    else $error("pwm period reload missing");
  a_pwm_no_cmpflag: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && pwm_on && !cmp2_f_q) |=> !cmp2_f_q)
    else $error("compare2 flag set in pwm");
  a_cap_two_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && cap1_f_q && !armed_q[4] && acc_i.cap1_lo_acc && !set_cap1) |=> cap1_f_q)
    else $error("capture flag cleared without flag read");
  a_hold_compare: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && cmp_hold_q[0] && !pulse_trig && !(pwm_on && match2)) |=> $stable(wave_q))
    else $error("compare active while held");
  a_wake_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && halt_wake_i && arm2_q && !cap2_inh_q) |=> cap2_f_q && cap2_q == $past(cnt_q))
    else $error("armed capture lost at wake");
  a_pwm_no_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && pwm_on && trig_edge && !halt_wake_i) |=> $stable(cap1_q))
    else $error("trigger captured in pwm");
  a_clk_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
    !clk_en_i |=> $stable(cnt_q) && $stable(wave_q) && $stable(flag_vec))
    else $error("state moved with clock enable low");
  a_halt_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
    (halt_i && !pulse_trig) |=> $stable(cnt_q))
    else $error("counter moved in halt");
  a_irq_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    core_mask_i |-> !timer_irq_o)
    else $error("interrupt despite mask");
  a_ovf_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_en_i && set_ovf) |=> cnt_q == 16'h0000 && ovf_f_q)
    else $error("rollover wrong");

endmodule

// file: tpwm_pkg.sv
// Package for the one-pulse / PWM timer block.
// Assumes a single 100 MHz clock domain and control ports grouped into one struct.
package tpwm_pkg;

  // ----------------------------------------
  // Counter constants
  // ----------------------------------------
  localparam logic [15:0] TPWM_RELOAD_VAL  = 16'hFFFC;
  localparam logic [15:0] TPWM_CAP1_PULSE  = 16'hFFFD;
  localparam logic [15:0] TPWM_CMP_RESET   = 16'h8000;
  localparam logic [15:0] TPWM_CNT_RESET   = 16'hFFFC;
  localparam logic [1:0]  TPWM_DIV4_SEL    = 2'h0;
  localparam logic [1:0]  TPWM_DIV2_SEL    = 2'h1;
  localparam logic [1:0]  TPWM_DIV8_SEL    = 2'h2;
  localparam logic [1:0]  TPWM_EXT_SEL     = 2'h3;
  localparam logic [2:0]  TPWM_DIV2_MASK   = 3'h1;
  localparam logic [2:0]  TPWM_DIV4_MASK   = 3'h3;
  localparam logic [2:0]  TPWM_DIV8_MASK   = 3'h7;

  // ----------------------------------------
  // Flag register field positions
  // ----------------------------------------
  localparam int TPWM_CAP1_POS = 7;
  localparam int TPWM_CMP1_POS = 6;
  localparam int TPWM_OVF_POS  = 5;
  localparam int TPWM_CAP2_POS = 4;
  localparam int TPWM_CMP2_POS = 3;

  typedef enum logic [2:0] {
    TPWM_MODE_NORMAL = 3'b001,
    TPWM_MODE_PULSE  = 3'b010,
    TPWM_MODE_PWM    = 3'b100
  } tpwm_mode_t;

  // Control bits grouped as one carrier
  typedef struct packed {
    logic       cap_irq_en;
    logic       cmp_irq_en;
    logic       ovf_irq_en;
    logic       cmp2_level;
    logic       edge1_sel;
    logic       cmp1_level;
    logic       wave1_pin_en;
    logic       single_pulse_sel;
    logic       pwm_sel;
    logic [1:0] tick_div_sel;
    logic       edge2_sel;
    logic       ext_edge_sel;
  } tpwm_ctrl_t;

  // Software access strobes, one cycle each
  typedef struct packed {
    logic       flag_reg_rd;
    logic       cap1_lo_acc;
    logic       cap2_lo_acc;
    logic       cap1_hi_rd;
    logic       cap2_hi_rd;
    logic       cmp1_lo_acc;
    logic       cmp2_lo_acc;
    logic       cnt_lo_acc;
    logic [1:0] cmp_hi_wr;
    logic [1:0] cmp_lo_wr;
    logic [7:0] wr_data;
  } tpwm_acc_t;

endpackage

// file: tpwm_partner.sv
// Far-side model: trigger and capture pin source, external clock, waveform load.
// Assumes one-cycle edge requests from the bench in the mclk domain.
`timescale 1ns/1ps
module tpwm_partner (
  input  wire logic        mclk_i,
  input  wire logic        fire_i,
  input  wire logic        rise_i,
  input  wire logic        cap2_fire_i,
  input  wire logic        ext_run_i,
  input  wire logic        wave_i,
  output logic             trig_o,
  output logic             cap2_o,
  output logic             ext_o,
  output logic [15:0]      high_len_o
);
  logic [15:0] run_q;
  logic [1:0]  ext_cnt_q;
  logic        wave_q;

  initial begin
    {trig_o, cap2_o, ext_o, wave_q} = 4'h0;
    high_len_o = 16'h0000;
    run_q = 16'h0000;
    ext_cnt_q = 2'h0;
  end

  // ----------------------------------------
  // Pin drive and load
  // ----------------------------------------
  // pins always driven by this source
  always @(posedge mclk_i) begin
    if (fire_i)
      trig_o <= rise_i;
    if (cap2_fire_i)
      cap2_o <= ~cap2_o;
    // Clock stands still unless asked to run
    if (ext_run_i) begin
      ext_cnt_q <= (ext_cnt_q == 2'h2) ? 2'h0 : ext_cnt_q + 2'h1;
      if (ext_cnt_q == 2'h2)
        ext_o <= ~ext_o;
    end
    wave_q <= wave_i;
    if (wave_i && !wave_q)
      run_q <= 16'h0001;
    else if (wave_i)
      run_q <= run_q + 16'h0001;
    if (!wave_i && wave_q)
      high_len_o <= run_q;
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the one-pulse / PWM timer.
// Assumes the partner drives the pins; controls and strobes come from here.
`timescale 1ns/1ps
module tb_top;
  import tpwm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        mclk, rst, core_mask, halt, gpio, halt_wake, clk_en;
  logic        fire, rise, cap2_fire, ext_run;
  logic        trig, cap2, ext_clk, wave, irq, wake;
  logic [15:0] cnt, cap1v, cap2v, cmp1v, cmp2v, high_len;
  logic [7:0]  flags;
  tpwm_ctrl_t  ctrl;
  tpwm_acc_t   acc;
  int          fail_count = 0;
  int          tests_run = 0;

  tpwm_timer dut (
    .mclk_i          (mclk),
    .rst_i           (rst),
    .clk_en_i        (clk_en),
    .ctrl_i          (ctrl),
    .acc_i           (acc),
    .core_mask_i     (core_mask),
    .halt_i          (halt),
    .halt_wake_i     (halt_wake),
    .trig_in1_i      (trig),
    .cap_in2_i       (cap2),
    .ext_clk_i       (ext_clk),
    .gpio_out_i      (gpio),
    .wave_out1_o     (wave),
    .counter_o       (cnt),
    .capture1_value_o(cap1v),
    .capture2_value_o(cap2v),
    .compare1_value_o(cmp1v),
    .compare2_value_o(cmp2v),
    .flag_reg_o      (flags),
    .timer_irq_o     (irq),
    .wait_wake_o     (wake)
  );

  tpwm_partner far (
    .mclk_i     (mclk),
    .fire_i     (fire),
    .rise_i     (rise),
    .cap2_fire_i(cap2_fire),
    .ext_run_i  (ext_run),
    .wave_i     (wave),
    .trig_o     (trig),
    .cap2_o     (cap2),
    .ext_o      (ext_clk),
    .high_len_o (high_len)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Phase of the prescaler is unknown, so lengths get one tick of slack
  task automatic check_in(input string what, input logic [15:0] seen, input int lo, input int hi);
    check(what, 16'(seen >= lo && seen <= hi), 16'h0001);
  endtask

  task automatic strobe(input tpwm_acc_t a);
    acc = a;
    tick(1);
    acc = '0;
    tick(1);
  endtask

  // high byte first, then low byte
  task automatic set_cmp(input int idx, input logic [15:0] v);
    tpwm_acc_t a;
    a = '0;
    a.cmp_hi_wr[idx] = 1'b1;
    a.wr_data = v[15:8];
    strobe(a);
    a = '0;
    a.cmp_lo_wr[idx] = 1'b1;
    a.wr_data = v[7:0];
    strobe(a);
  endtask

  task automatic trig_edge(input logic r);
    rise = r;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    tick(3);
  endtask

  task automatic wait_wave(input logic lvl);
    int n;
    n = 0;
    while (wave !== lvl && n < 300) begin
      tick(1);
      n++;
    end
    check("wave level", 16'(wave), 16'(lvl));
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("counter", cnt, 16'hFFFC);
    check("compare1", cmp1v, 16'h8000);
    check("compare2", cmp2v, 16'h8000);
    check("capture1", cap1v, 16'h0000);
    check("flags", 16'(flags), 16'h0000);
    tick(24);
    check("overflow flag", 16'(flags[5]), 16'h0001);
  endtask

  task automatic t_pulse();
    tpwm_ctrl_t c;
    c = '0;
    c.single_pulse_sel = 1'b1;
    c.wave1_pin_en = 1'b1;
    c.cmp2_level = 1'b1;
    c.tick_div_sel = TPWM_DIV2_SEL;
    c.cap_irq_en = 1'b1;
    c.edge2_sel = 1'b1;
    ctrl = c;
    set_cmp(0, 16'h0004);
    trig_edge(1'b1);
    check("wrong edge", 16'(flags[7]), 16'h0000);
    trig_edge(1'b0);
    check("capture1", cap1v, 16'hFFFD);
    check("cap1 flag", 16'(flags[7]), 16'h0001);
    check("pulse level", 16'(wave), 16'h0001);
    check("irq", 16'(irq), 16'h0001);
    cap2_fire = 1'b1;
    tick(1);
    cap2_fire = 1'b0;
    tick(3);
    check("cap2 flag", 16'(flags[4]), 16'h0001);
    wait_wave(1'b0);
    tick(2);
    check_in("pulse len", high_len, 16, 20);
    check("cmp1 flag", 16'(flags[6]), 16'h0000);
  endtask

  task automatic t_clear();
    tpwm_acc_t a;
    a = '0;
    a.cap1_lo_acc = 1'b1;
    strobe(a);
    check("no read first", 16'(flags[7]), 16'h0001);
    a = '0;
    a.flag_reg_rd = 1'b1;
    strobe(a);
    a = '0;
    a.cap1_lo_acc = 1'b1;
    a.cap2_lo_acc = 1'b1;
    strobe(a);
    check("cap flags", 16'({flags[7], flags[4]}), 16'h0000);
    check("irq off", 16'(irq), 16'h0000);
  endtask

  task automatic t_pwm();
    tpwm_ctrl_t c;
    c = ctrl;
    c.pwm_sel = 1'b1;
    c.cmp_irq_en = 1'b1;
    ctrl = c;
    // Restart so the counter starts at FFFC and soon wraps below the new period
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    check("reset count", cnt, 16'hFFFC);
    set_cmp(1, 16'h0008);
    set_cmp(0, 16'h0002);
    trig_edge(1'b1);
    trig_edge(1'b0);
    check("no trig capture", cap1v, 16'h0000);
    wait_wave(1'b1);
    wait_wave(1'b0);
    tick(2);
    check_in("pwm high", high_len, 12, 16);
    check("cap1 flag", 16'(flags[7]), 16'h0001);
    check("cmp flags", 16'({flags[6], flags[3]}), 16'h0000);
    check("irq", 16'(irq), 16'h0001);
    core_mask = 1'b1;
    tick(1);
    check("masked irq", 16'(irq), 16'h0000);
    core_mask = 1'b0;
    c.cmp1_level = 1'b1;
    c.cmp2_level = 1'b0;
    ctrl = c;
    wait_wave(1'b1);
    wait_wave(1'b0);
    tick(2);
    check_in("pwm gap", high_len, 10, 14);
    c.cmp2_level = 1'b1;
    ctrl = c;
    tick(60);
    check("even levels", 16'(wave), 16'h0001);
    c.wave1_pin_en = 1'b0;
    ctrl = c;
    tick(1);
    check("port low", 16'(wave), 16'h0000);
    gpio = 1'b1;
    tick(1);
    check("port high", 16'(wave), 16'h0001);
  endtask

  task automatic t_div();
    tpwm_ctrl_t c;
    logic [15:0] c0;
    int div [4] = '{4, 2, 8, 6};
    for (int s = 0; s < 4; s++) begin
      c = '0;
      c.tick_div_sel = 2'(s);
      c.ext_edge_sel = 1'b1;
      ctrl = c;
      ext_run = 1'(s == 3);
      tick(8);
      c0 = cnt;
      tick(96);
      check_in("tick rate", cnt - c0, 96 / div[s] - 1, 96 / div[s] + 1);
    end
    ext_run = 1'b0;
  endtask

  task automatic t_halt();
    tpwm_ctrl_t c;
    logic [15:0] c0;
    c = '0;
    c.tick_div_sel = TPWM_DIV2_SEL;
    c.ovf_irq_en = 1'b1;
    ctrl = c;
    halt = 1'b1;
    tick(2);
    c0 = cnt;
    cap2_fire = 1'b1;
    tick(1);
    cap2_fire = 1'b0;
    tick(19);
    check("halted count", cnt, c0);
    check("halt capture", 16'(flags[4]), 16'h0000);
    check("halt wake", 16'(wake), 16'h0000);
    halt = 1'b0;
    halt_wake = 1'b1;
    tick(1);
    halt_wake = 1'b0;
    check("wake flag", 16'(flags[4]), 16'h0001);
    check("wake capture", cap2v, c0);
    tick(9);
    check_in("resume", cnt - c0, 3, 6);
    check("wait wake", 16'(wake), 16'h0001);
    c0 = cnt;
    clk_en = 1'b0;
    tick(8);
    check("frozen count", cnt, c0);
    clk_en = 1'b1;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {rst, core_mask, halt, gpio, fire, rise, cap2_fire, ext_run} = 8'h80;
    ctrl = '0;
    acc = '0;
    clk_en = 1'b1;
    halt_wake = 1'b0;
    tick(2);
    rst = 1'b0;
    t_reset();
    t_pulse();
    t_clear();
    t_pwm();
    t_div();
    t_halt();
    give_verdict();
  end
endmodule
